/* File: verilog/adcseq_pkg.sv */
// adcseq_pkg: shared constants and types for the reading sequencer
package adcseq_pkg;
	// ---------------------------------------------------------------
	// reading modes and commands
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		one_channel_one_read_mode,
		one_channel_continuous_mode,
		multi_channel_one_pass_mode,
		multi_channel_multi_read_mode,
		multi_channel_continuous_mode
	} adcseq_mode_t;

	// ---------------------------------------------------------------
	// sizes and timing
	// ---------------------------------------------------------------
	localparam int NUM_CHANNELS    = 16;
	localparam int DELAY_CODES     = 34;
	localparam int DELAY_CODE_W    = 6;
	localparam int DELAY_CNT_W     = 15;
	localparam int SYSCLK_DIV      = 2;
	localparam int FIRST_OVERHEAD  = 4;
	localparam int NORMAL_SETTLE   = 4;
	localparam int SINGLE_SETTLE   = 1;
	localparam int FIRST_STAGE_MIN_SPS = 12000;
	localparam int CASCADE_MAX_SPS     = 9000;
	localparam logic [DELAY_CODE_W-1:0] DELAY_CODE_RST = 6'h00;
	localparam logic [NUM_CHANNELS-1:0] CH_ENABLE_RST  = 16'h0001;

	// programmable delay, system clocks per code
	function automatic logic [DELAY_CNT_W-1:0] delay_cycles(input logic [DELAY_CODE_W-1:0] c);
		logic [DELAY_CNT_W-1:0] r;
		r = 15'h0000;
		case (c)
			6'h00: r = 15'h0000;
			6'h01: r = 15'h0002;
			6'h02: r = 15'h0004;
			6'h03: r = 15'h0006;
			6'h04: r = 15'h0008;
			6'h05: r = 15'h000a;
			6'h06: r = 15'h000c;
			6'h07: r = 15'h000e;
			6'h08: r = 15'h0010;
			6'h09: r = 15'h0012;
			6'h0a: r = 15'h0014;
			6'h0b: r = 15'h001c;
			6'h0c: r = 15'h0026;
			6'h0d: r = 15'h0028;
			6'h0e: r = 15'h002a;
			6'h0f: r = 15'h0038;
			6'h10: r = 15'h0040;
			6'h11: r = 15'h004c;
			6'h12: r = 15'h005a;
			6'h13: r = 15'h0080;
			6'h14: r = 15'h009a;
			6'h15: r = 15'h00b2;
			6'h16: r = 15'h00cc;
			6'h17: r = 15'h00e0;
			6'h18: r = 15'h0100;
			6'h19: r = 15'h0166;
			6'h1a: r = 15'h0200;
			6'h1b: r = 15'h02cc;
			6'h1c: r = 15'h0400;
			6'h1d: r = 15'h0680;
			6'h1e: r = 15'h0ccc;
			6'h1f: r = 15'h1e00;
			6'h20: r = 15'h4b00;
			6'h21: r = 15'h5a00;
			default: r = 15'h0000;
		endcase
		return r;
	endfunction
endpackage

/* File: verilog/adcseq_sync.sv */
// adcseq_sync: three-stage input synchroniser with agreement filter
module adcseq_sync (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic pin_in,
	output logic      level_q
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} adcseq_sync_t;

	adcseq_sync_t st_q;
	adcseq_sync_t st_d;

	// first stage feeds only the second; level moves when stages two and three agree
	always_comb
	begin
		st_d     = st_q;
		st_d.s1  = pin_in;
		st_d.s2  = st_q.s1;
		st_d.s3  = st_q.s2;
		if (st_q.s2 == st_q.s3)
		begin
			st_d.lvl = st_q.s3;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign level_q = st_q.lvl;
endmodule // adcseq_sync

/* File: verilog/adcseq_core.sv */
// adcseq_core: reading sequencer for the converter
module adcseq_core #(
	parameter int NUM_CH = adcseq_pkg::NUM_CHANNELS
) (
	input  wire logic                                 sys_clk,
	input  wire logic                                 sys_rst,
	input  wire logic                                 cmd_one_channel_one_read,
	input  wire logic                                 cmd_one_channel_continuous,
	input  wire logic                                 cmd_multi_channel_one_pass,
	input  wire logic                                 cmd_multi_channel_multi_read,
	input  wire logic                                 cmd_multi_channel_continuous,
	input  wire logic                                 cmd_end,
	input  wire logic                                 cmd_abort,
	input  wire logic                                 trigger_source,
	input  wire logic                                 trigger_pin,
	input  wire logic [NUM_CH-1:0]                    channel_enable,
	input  wire logic [adcseq_pkg::DELAY_CODE_W-1:0]  delay_code,
	input  wire logic                                 single_cycle_settling,
	input  wire logic [31:0]                          output_rate_sps,
	input  wire logic                                 conv_done,
	output logic                                      busy,
	output logic [$clog2(NUM_CH)-1:0]                 channel_sel,
	output logic                                      channel_cfg_load,
	output logic                                      conv_start,
	output logic                                      conv_abort,
	output logic                                      result_ready,
	output logic [2:0]                                settle_samples,
	output logic                                      cascade_second_stage,
	output logic [2:0]                                active_mode
);
	localparam int CW = $clog2(NUM_CH);

	// ---------------------------------------------------------------
	// elaboration check
	// ---------------------------------------------------------------
	if (NUM_CH < 2 || NUM_CH > 32)
	begin : g_bad_num_ch
		$error("adcseq_core: NUM_CH must lie in 2..32");
	end

	typedef enum logic [2:0] {
		st_idle,
		st_overhead,
		st_config,
		st_delay,
		st_convert
	} adcseq_state_t;

	typedef struct packed {
		adcseq_state_t           state;
		adcseq_pkg::adcseq_mode_t mode;
		logic                    armed;
		logic                    end_req;
		logic                    trig_prev;
		logic [CW-1:0]           ch;
		logic [adcseq_pkg::DELAY_CNT_W-1:0] cnt;
		logic                    busy;
		logic                    cfg_load;
		logic                    start;
		logic                    abort;
		logic                    ready;
		logic [2:0]              settle;
		logic                    cascade;
	} adcseq_core_t;

	adcseq_core_t st_q;
	adcseq_core_t st_d;
	logic         trig_lvl;

	// trigger pin crosses from the host side
	adcseq_sync u_trig_sync (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.pin_in  (trigger_pin),
		.level_q (trig_lvl)
	);

	// next enabled channel after a given one, wrapping; flags wrap for end of pass
	function automatic logic [CW:0] next_channel(input logic [CW-1:0] cur,
			input logic [NUM_CH-1:0] en);
		logic [CW:0] r;
		logic        found;
		int          idx;
		r     = {1'b1, cur};
		found = 1'b0;
		for (int i = 1; i <= NUM_CH; i++)
		begin
			idx = (int'(cur) + i) % NUM_CH;
			if (!found && en[idx])
			begin
				found = 1'b1;
				r     = {((int'(cur) + i) >= NUM_CH) ? 1'b1 : 1'b0, CW'(idx)};
			end
		end
		return r;
	endfunction

	// first enabled channel, channel zero when none is set
	function automatic logic [CW-1:0] first_channel(input logic [NUM_CH-1:0] en);
		logic [CW-1:0] r;
		logic          found;
		r     = '0;
		found = 1'b0;
		for (int i = 0; i < NUM_CH; i++)
		begin
			if (!found && en[i])
			begin
				found = 1'b1;
				r     = CW'(i);
			end
		end
		return r;
	endfunction

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	logic          any_cmd;
	logic          trig_rise;
	logic          start_evt;
	logic          multi;
	logic          cont;
	logic [CW:0]   nxt;

	always_comb
	begin
		st_d          = st_q;
		st_d.cfg_load = 1'b0;
		st_d.start    = 1'b0;
		st_d.abort    = 1'b0;
		st_d.ready    = 1'b0;
		st_d.trig_prev = trig_lvl;
		any_cmd = 1'b1;
		// each command selects its own mode
		if (cmd_one_channel_one_read)
		begin
			st_d.mode = adcseq_pkg::one_channel_one_read_mode;
		end
		else if (cmd_one_channel_continuous)
		begin
			st_d.mode = adcseq_pkg::one_channel_continuous_mode;
		end
		else if (cmd_multi_channel_one_pass)
		begin
			st_d.mode = adcseq_pkg::multi_channel_one_pass_mode;
		end
		else if (cmd_multi_channel_multi_read)
		begin
			st_d.mode = adcseq_pkg::multi_channel_multi_read_mode;
		end
		else if (cmd_multi_channel_continuous)
		begin
			st_d.mode = adcseq_pkg::multi_channel_continuous_mode;
		end
		else
		begin
			any_cmd = 1'b0;
		end
		if (any_cmd)
		begin
			st_d.armed = 1'b1;
		end
		trig_rise = trig_lvl && !st_q.trig_prev;
		// command pulse marks the last falling spi clock edge
		// trigger rise reuses the most recent valid command
		start_evt = trigger_source ? (trig_rise && st_q.armed) : any_cmd;
		multi = (st_d.mode == adcseq_pkg::multi_channel_one_pass_mode) ||
			(st_d.mode == adcseq_pkg::multi_channel_multi_read_mode) ||
			(st_d.mode == adcseq_pkg::multi_channel_continuous_mode);
		cont = (st_q.mode == adcseq_pkg::one_channel_continuous_mode) ||
			(st_q.mode == adcseq_pkg::multi_channel_continuous_mode);
		nxt = next_channel(st_q.ch, channel_enable);
		// filter settling follows single_cycle_settling; stage choice follows the rate setting
		st_d.settle  = single_cycle_settling ? 3'(adcseq_pkg::SINGLE_SETTLE)
			: 3'(adcseq_pkg::NORMAL_SETTLE);
		st_d.cascade = (output_rate_sps <= 32'(adcseq_pkg::CASCADE_MAX_SPS));
		case (st_q.state)
			st_idle:
			begin
				// wait for a start event
				if (start_evt)
				begin
					st_d.busy    = 1'b1;
					st_d.end_req = 1'b0;
					st_d.ch      = multi ? first_channel(channel_enable) : '0;
					// first reading carries a fixed overhead
					st_d.cnt     = adcseq_pkg::DELAY_CNT_W'(adcseq_pkg::FIRST_OVERHEAD - 1);
					st_d.state   = st_overhead;
				end
			end
			st_overhead:
			begin
				if (st_q.cnt == '0)
				begin
					st_d.state = st_config;
				end
				else
				begin
					st_d.cnt = st_q.cnt - 1'b1;
				end
			end
			st_config:
			begin
				// configuration applied before delay or conversion
				st_d.cfg_load = 1'b1;
				// delay counted in undivided system clocks
				st_d.cnt      = adcseq_pkg::delay_cycles(delay_code);
				st_d.state    = st_delay;
			end
			st_delay:
			begin
				// conversion waits for the timer
				if (st_q.cnt == '0)
				begin
					st_d.start = 1'b1;
					st_d.state = st_convert;
				end
				else
				begin
					st_d.cnt = st_q.cnt - 1'b1;
				end
			end
			st_convert:
			begin
				// conversion runs to its done flag
				if (conv_done)
				begin
					st_d.ready = 1'b1;
					if (st_q.mode == adcseq_pkg::multi_channel_one_pass_mode ||
						st_q.mode == adcseq_pkg::multi_channel_multi_read_mode ||
						st_q.mode == adcseq_pkg::multi_channel_continuous_mode)
					begin
						st_d.ch = nxt[CW-1:0];
					end
					if (st_q.end_req)
					begin
						st_d.state = st_idle;
					end
					else if (cont)
					begin
						st_d.state = st_config;
					end
					else if (st_q.mode == adcseq_pkg::multi_channel_multi_read_mode && !nxt[CW])
					begin
						st_d.state = st_config;
					end
					else
					begin
						st_d.state = st_idle;
					end
				end
			end
			default:
			begin
				st_d.state = st_idle;
			end
		endcase
		if (st_q.state != st_idle && st_d.state == st_idle)
		begin
			st_d.busy = 1'b0;
		end
		// end lets the conversion finish; abort drops it now
		if (cmd_end && st_q.state != st_idle)
		begin
			if (st_q.state == st_convert)
			begin
				st_d.end_req = !conv_done;
				// end landing with done must not let a continuous mode loop on
				if (conv_done)
				begin
					st_d.state = st_idle;
					st_d.busy  = 1'b0;
				end
			end
			else
			begin
				st_d.state = st_idle;
				st_d.busy  = 1'b0;
			end
		end
		if (cmd_abort && st_q.state != st_idle)
		begin
			st_d.abort = (st_q.state == st_convert);
			st_d.ready = 1'b0;
			st_d.state = st_idle;
			st_d.busy  = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all from flip-flops
	// ---------------------------------------------------------------
	assign busy                 = st_q.busy;
	assign channel_sel          = st_q.ch;
	assign channel_cfg_load     = st_q.cfg_load;
	assign conv_start           = st_q.start;
	assign conv_abort           = st_q.abort;
	assign result_ready         = st_q.ready;
	assign settle_samples       = st_q.settle;
	assign cascade_second_stage = st_q.cascade;
	assign active_mode          = st_q.mode;
endmodule // adcseq_core

/* File: verification/adcseq_conv_model.sv */
// adcseq_conv_model: converter stand-in that answers conv_start after lat cycles
module adcseq_conv_model (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       conv_start,
	input  wire logic       conv_abort,
	input  wire logic [3:0] lat,
	output logic            conv_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	// lat of 0 is read as 1 so every start gets an answer
	always @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt <= 4'h0;
			conv_done <= 1'b0;
		end
		else
		begin
			conv_done <= (cnt == 4'h1) && !conv_abort;
			if (conv_abort)
				cnt <= 4'h0;
			else if (conv_start)
				cnt <= (lat == 4'h0) ? 4'h1 : lat;
			else if (cnt != 4'h0)
				cnt <= cnt - 4'h1;
		end
	end
endmodule // adcseq_conv_model

/* File: verification/adcseq_chk.sv */
// adcseq_chk: port-level assertions for the reading sequencer
module adcseq_chk #(
	parameter int NUM_CH = 16
) (
	input wire logic                    sys_clk,
	input wire logic                    sys_rst,
	input wire logic                    cmd_one_channel_one_read,
	input wire logic                    cmd_one_channel_continuous,
	input wire logic                    cmd_multi_channel_one_pass,
	input wire logic                    cmd_multi_channel_multi_read,
	input wire logic                    cmd_multi_channel_continuous,
	input wire logic                    cmd_abort,
	input wire logic                    trigger_source,
	input wire logic [5:0]              delay_code,
	input wire logic                    single_cycle_settling,
	input wire logic [31:0]             output_rate_sps,
	input wire logic                    conv_done,
	input wire logic                    busy,
	input wire logic                    channel_cfg_load,
	input wire logic                    conv_start,
	input wire logic                    conv_abort,
	input wire logic                    result_ready,
	input wire logic [2:0]              settle_samples,
	input wire logic                    cascade_second_stage,
	input wire logic [2:0]              active_mode
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic        seen_q;
	logic [15:0] since_q;
	logic        hi_cmd;
	assign hi_cmd = cmd_one_channel_one_read | cmd_one_channel_continuous
		| cmd_multi_channel_one_pass | cmd_multi_channel_multi_read;
	// saturating count keeps long delays from wrapping into a false pass
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			seen_q <= 1'b0;
			since_q <= 16'h0000;
		end
		else
		begin
			seen_q <= channel_cfg_load | (seen_q & !conv_start);
			since_q <= channel_cfg_load ? 16'h0000 : since_q + {15'h0000, ~&since_q};
		end
	end
	a_mode_first: assert property (cmd_one_channel_one_read |=> active_mode == 3'h0)
		else $error("mode not one channel one read");
	a_mode_last: assert property (cmd_multi_channel_continuous && !hi_cmd |=> active_mode == 3'h4)
		else $error("mode not multi continuous");
	a_idle_start: assert property ($rose(busy) && !trigger_source |-> $past(hi_cmd | cmd_multi_channel_continuous))
		else $error("start without command");
	a_cfg_first: assert property (conv_start |-> seen_q)
		else $error("conversion without configuration");
	a_first_gap: assert property ($rose(busy) |-> !channel_cfg_load [*5] ##1 (channel_cfg_load || !busy))
		else $error("first configuration not after fixed overhead");
	a_delay_hold: assert property (conv_start && delay_code <= 6'h0a |-> since_q >= {9'h000, delay_code, 1'b0})
		else $error("conversion before delay expired");
	a_start_pulse: assert property (conv_start |-> busy ##1 !conv_start)
		else $error("conversion start not single pulse");
	a_ready_done: assert property (result_ready |-> $past(conv_done))
		else $error("result ready without conversion done");
	a_abort_idle: assert property (cmd_abort && busy |-> ##[1:4] !busy)
		else $error("abort did not reach idle");
	a_abort_drop: assert property (conv_abort |-> ##1 !result_ready [*2])
		else $error("result after abort");
	a_settle_cnt: assert property (!$past(sys_rst) |-> settle_samples == ($past(single_cycle_settling) ? 3'h1 : 3'h4))
		else $error("settle sample count wrong");
	a_cascade_sel: assert property (!$past(sys_rst) |-> cascade_second_stage == ($past(output_rate_sps) <= 32'h0000_2328))
		else $error("second stage selection wrong");
endmodule // adcseq_chk
bind adcseq_core adcseq_chk #(.NUM_CH(NUM_CH)) u_chk (.*);

/* File: verification/adc_reading_sequencer_tb_top.sv */
// adc_reading_sequencer_tb_top: random and corner sequences for the reading sequencer
module adc_reading_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, sys_rst = 1, trigger_source = 0, trigger_pin = 0, cmd_end = 0;
	logic cmd_abort = 0, single_cycle_settling = 0, conv_done;
	logic cmd_one_channel_one_read = 0, cmd_one_channel_continuous = 0;
	logic cmd_multi_channel_one_pass = 0, cmd_multi_channel_multi_read = 0;
	logic cmd_multi_channel_continuous = 0;
	logic [15:0] channel_enable = 16'h0001;
	logic [5:0]  delay_code = 6'h00;
	logic [31:0] output_rate_sps = 32'h0000_2ee0;
	logic [3:0]  lat = 4'h3, channel_sel;
	logic busy, channel_cfg_load, conv_start, conv_abort, result_ready, cascade_second_stage;
	logic [2:0]  settle_samples, active_mode;
	int n_mismatch = 0, comparisons = 0, nres = 0, nab = 0, gap = 0, cyc = 0, i, k, n;
	logic [3:0] chq[$];
	int gq[$];
	adcseq_core u_dut (.*);
	adcseq_conv_model u_conv (.sys_clk, .sys_rst, .conv_start, .conv_abort, .lat, .conv_done);
	always #5 sys_clk = ~sys_clk;
	// ---------------------------------------------------------------
	// monitor and timeout
	// ---------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		cyc++;
		gap = channel_cfg_load ? 0 : gap + 1;
		nres += result_ready;
		nab += conv_abort;
		if (conv_start)
		begin
			chq.push_back(channel_sel);
			gq.push_back(gap);
		end
		if (cyc > 60000)
		begin
			n_mismatch++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	function automatic int nth(input logic [15:0] m, input int j);
		int c;
		c = 0;
		for (int b = 0; b < 16; b++)
			if (m[b])
			begin
				if (c == j)
					return b;
				c++;
			end
		return 0;
	endfunction
	function automatic int dly(input int c);
		return (c == 33) ? 23040 : 2 * c;
	endfunction
	// one command pulse per call; wait_idle does the bounded wait until the sequence idles
	task automatic run(input int c);
		chq.delete();
		gq.delete();
		nres = 0;
		nab = 0;
		@(negedge sys_clk);
		{cmd_one_channel_one_read, cmd_one_channel_continuous, cmd_multi_channel_one_pass,
			cmd_multi_channel_multi_read, cmd_multi_channel_continuous} = 5'h10 >> c;
		@(negedge sys_clk);
		{cmd_one_channel_one_read, cmd_one_channel_continuous, cmd_multi_channel_one_pass,
			cmd_multi_channel_multi_read, cmd_multi_channel_continuous} = 5'h00;
	endtask
	task automatic wait_idle();
		for (int w = 0; w < 30000 && busy !== 1'b0; w++)
			@(negedge sys_clk);
		// ready and abort pulses leave with busy low; let the monitor count them
		@(negedge sys_clk);
		chk(busy, 1'b0);
	endtask
	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		n = $urandom(32'hc4eb);
		repeat (10) @(negedge sys_clk);
		sys_rst = 0;
		// one channel single reads across delay codes, code 33 as the long corner
		for (i = 0; i < 12; i++)
		begin
			delay_code = (i == 11) ? 6'h21 : 6'(i);
			lat = 4'($urandom_range(1, 8));
			single_cycle_settling = 1'($urandom);
			output_rate_sps = (i < 2) ? 32'h0000_2328 + i : 32'($urandom_range(1, 20000));
			run(0);
			wait_idle();
			chk(nres, 1);
			chk(chq.size(), 1);
			chk(chq[0], 0);
			chk(gq[0] >= dly(delay_code) && gq[0] <= dly(delay_code) + 2, 1);
			chk(settle_samples, single_cycle_settling ? 3'h1 : 3'h4);
			chk(cascade_second_stage, output_rate_sps <= 9000);
			chk(active_mode, 3'h0);
		end
		delay_code = 6'h02;
		// multichannel pass and multi-read over random and edge masks
		for (i = 0; i < 6; i++)
		begin
			channel_enable = (i == 0) ? 16'h8000 : (i == 1) ? 16'hffff : 16'($urandom) | 16'h0010;
			run(2);
			wait_idle();
			chk(chq[0], nth(channel_enable, 0));
			chk(active_mode, 3'h2);
			run(3);
			wait_idle();
			chk(nres, $countones(channel_enable));
			for (k = 0; k < chq.size(); k++)
				chk(chq[k], nth(channel_enable, k));
		end
		// continuous modes loop until end, end lets the conversion finish
		for (i = 1; i < 5; i += 3)
		begin
			run(i);
			// end is sent while a conversion is in flight
			for (k = 0; k < 2000 && (nres < 3 || chq.size() == nres); k++)
				@(negedge sys_clk);
			cmd_end = 1;
			@(negedge sys_clk);
			cmd_end = 0;
			wait_idle();
			chk(nres >= 3, 1);
			chk(chq.size(), nres);
			for (k = 0; k < chq.size(); k++)
				chk(chq[k], (i == 1) ? 0 : nth(channel_enable, k % $countones(channel_enable)));
		end
		// abort while converting drops the result
		lat = 4'h8;
		run(4);
		for (k = 0; k < 100 && chq.size() == 0; k++)
			@(negedge sys_clk);
		cmd_abort = 1;
		@(negedge sys_clk);
		cmd_abort = 0;
		wait_idle();
		chk(nab, 1);
		chk(nres, 0);
		// trigger pin start with the latest mode
		trigger_source = 1;
		run(0);
		run(3);
		repeat (10) @(negedge sys_clk);
		chk(busy, 1'b0);
		trigger_pin = 1;
		repeat (6) @(negedge sys_clk);
		trigger_pin = 0;
		for (k = 0; k < 20 && busy !== 1'b1; k++)
			@(negedge sys_clk);
		wait_idle();
		chk(nres, $countones(channel_enable));
		finish_test();
	end
endmodule // adc_reading_sequencer_tb_top
